// ==== vtpg_pkg.sv ====
// Package of register map, field layout and constants for the video test pattern generator
package vtpg_pkg;
	// --------------------------------------------------------------
	// Register indices (byte address = 4 * index)
	// --------------------------------------------------------------
	localparam logic [7:0] IDX_NONE = 8'h00;
	localparam logic [7:0] IDX_CTL = 8'h64;
	localparam logic [7:0] IDX_CFG = 8'h65;
	localparam logic [7:0] IDX_IA = 8'h66;
	localparam logic [7:0] IDX_ID = 8'h67;
	localparam logic [7:0] IDX_RED = 8'h68;
	localparam logic [7:0] IDX_GRN = 8'h69;
	localparam logic [7:0] IDX_BLU = 8'h6A;
	localparam logic [7:0] IDX_TSC = 8'h6B;
	// --------------------------------------------------------------
	// Field positions and encodings
	// --------------------------------------------------------------
	localparam int CTL_SEL_W = 5;
	localparam int CTL_CHK_CUST = 5;
	localparam int CTL_VCOM_REV = 6;
	localparam int CFG_INV = 0;
	localparam int CFG_18B = 1;
	localparam int CFG_MODE_LSB = 2;
	localparam int CFG_SCROLL = 4;
	localparam int TSC_HOLD_LSB = 0;
	localparam int TSC_LAST_LSB = 4;
	localparam int CHK_BIT = 6;
	localparam logic [1:0] TM_EXT = 2'h0;
	localparam logic [1:0] TM_INT = 2'h1;
	localparam logic [1:0] TM_INT_XCLK = 2'h2;
	localparam logic [7:0] LSB_MASK = 8'hFC;
	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic [7:0] CTL_RST = 8'h01;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] TSC_RST = 8'h00;
	localparam logic [7:0] LVL_RST = 8'h00;
	// --------------------------------------------------------------
	// Indirect map
	// --------------------------------------------------------------
	localparam int IND_DEPTH = 24;
	localparam logic [4:0] IND_HACT = 5'h00;
	localparam logic [4:0] IND_HTOT = 5'h02;
	localparam logic [4:0] IND_HSW = 5'h04;
	localparam logic [4:0] IND_VACT = 5'h05;
	localparam logic [4:0] IND_VTOT = 5'h07;
	localparam logic [4:0] IND_VSW = 5'h09;
	localparam logic [4:0] IND_OSC = 5'h0A;
	localparam logic [4:0] IND_SLOT = 5'h10;
	localparam logic [7:0] IND_HMEAS = 8'h18;
	localparam logic [7:0] IND_VMEAS = 8'h1A;
	localparam logic [11:0] HACT_RST = 12'h280;
	localparam logic [11:0] HTOT_RST = 12'h320;
	localparam logic [7:0] HSW_RST = 8'h60;
	localparam logic [11:0] VACT_RST = 12'h1E0;
	localparam logic [11:0] VTOT_RST = 12'h20D;
	localparam logic [7:0] VSW_RST = 8'h02;
	localparam logic [7:0] OSC_RST = 8'h03;
	// --------------------------------------------------------------
	// Pattern numbers
	// --------------------------------------------------------------
	localparam logic [4:0] PAT_WHITE = 5'h01;
	localparam logic [4:0] PAT_BLACK = 5'h02;
	localparam logic [4:0] PAT_RED = 5'h03;
	localparam logic [4:0] PAT_GREEN = 5'h04;
	localparam logic [4:0] PAT_BLUE = 5'h05;
	localparam logic [4:0] PAT_HGRAY = 5'h06;
	localparam logic [4:0] PAT_VGRAY = 5'h0A;
	localparam logic [4:0] PAT_CUSTOM = 5'h0E;
	localparam logic [4:0] PAT_CHECK = 5'h0F;
	localparam logic [4:0] PAT_VCOM = 5'h10;
	localparam logic [4:0] PAT_BARS = 5'h11;
endpackage

// ==== vtpg_top.sv ====
// Video test pattern generator with timing, scrolling and AHB-Lite registers
`timescale 1ns/1ps
// Overview of operation
// - Seventeen selectable patterns including ramps and bars
// - Inversion bit flips every active colour bit, before the 18-bit mask
// - Pattern fourteen uses three custom colour levels
// - Scroll off: static pattern from control register
// - Scroll on: timing and order slots choose
// - Up to sixteen entries, any order, repeats
// - Colour bars never appear while scrolling
// - Custom checker colour, reversible vertical-stripe colour order
// - Default drives all eight colour bits
// - 18-bit mode drives bits seven to two
// - Starts external timing; internal modes selectable
// - No vsync: frame ends after blank of twice measured active width
// - External syncs forwarded two pixel clocks late
// - Measure active size to scale ramps under external timing
// - Internal timing from programmed counter registers
// - Pattern shown even without video input
// - Internal oscillator tick when no pixel clock
// - Indirect index at 0x66, data at 0x67
module vtpg_top
	import vtpg_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic PIX_VALID,
	input wire logic DE_IN,
	input wire logic HS_IN,
	input wire logic VS_IN,
	output logic DE_OUT,
	output logic HS_OUT,
	output logic VS_OUT,
	output logic [7:0] RED_OUT,
	output logic [7:0] GREEN_OUT,
	output logic [7:0] BLUE_OUT
);
	logic [7:0] ctl, cfg, ia, red_lv, grn_lv, blu_lv, tsc;
	logic [7:0] ind_mem [0:IND_DEPTH-1];
	logic pend, pend_wr, wr;
	logic [7:0] pend_idx;
	logic [7:0] osc_cnt;
	logic osc_tick, tick, ext_mode, auto, frame_end;
	logic [1:0] tmode;
	logic [11:0] hcnt, vcnt, x, y, h_meas, v_meas;
	logic [11:0] hact, htot, vact, vtot, hsize, vsize;
	logic [12:0] blank_cnt;
	logic d1_de, d1_hs, d1_vs, src_de, src_hs, src_vs;
	logic [3:0] slot, frame_cnt;
	logic [4:0] cur_pat;
	logic [23:0] pix;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic [11:0] dim(input logic [7:0] lo, input logic [7:0] hi);
		return {hi[3:0], lo};
	endfunction

	function automatic logic [7:0] scale(input logic [11:0] pos, input logic [11:0] size);
		logic [19:0] q;
		q = (size == 12'h000) ? 20'h00000 : ({pos, 8'h00} / {8'h00, size});
		return (q > 20'h000FF) ? 8'hFF : q[7:0];
	endfunction

	function automatic logic [7:0] ind_default(input int i);
		case (i)
			int'(IND_HACT): return HACT_RST[7:0];
			int'(IND_HACT) + 1: return {4'h0, HACT_RST[11:8]};
			int'(IND_HTOT): return HTOT_RST[7:0];
			int'(IND_HTOT) + 1: return {4'h0, HTOT_RST[11:8]};
			int'(IND_HSW): return HSW_RST;
			int'(IND_VACT): return VACT_RST[7:0];
			int'(IND_VACT) + 1: return {4'h0, VACT_RST[11:8]};
			int'(IND_VTOT): return VTOT_RST[7:0];
			int'(IND_VTOT) + 1: return {4'h0, VTOT_RST[11:8]};
			int'(IND_VSW): return VSW_RST;
			int'(IND_OSC): return OSC_RST;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] rd_ind(input logic [7:0] idx);
		if (idx < 8'(IND_DEPTH))
			return ind_mem[idx[4:0]];
		case (idx)
			IND_HMEAS: return h_meas[7:0];
			IND_HMEAS + 8'h01: return {4'h0, h_meas[11:8]};
			IND_VMEAS: return v_meas[7:0];
			IND_VMEAS + 8'h01: return {4'h0, v_meas[11:8]};
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] rd_reg(input logic [7:0] idx);
		case (idx)
			IDX_CTL: return ctl;
			IDX_CFG: return cfg;
			IDX_IA: return ia;
			IDX_ID: return rd_ind(ia);
			IDX_RED: return red_lv;
			IDX_GRN: return grn_lv;
			IDX_BLU: return blu_lv;
			IDX_TSC: return tsc;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [4:0] slot_pat(input logic [3:0] s);
		logic [7:0] b;
		b = ind_mem[IND_SLOT + {2'h0, s[3:1]}];
		return {1'b0, (s[0] ? b[7:4] : b[3:0])} + 5'h01;
	endfunction

	// ----------------------------------------------------------------
	// AHB-Lite slave, one wait state per transfer
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N)
		if (!RST_N)
		begin
			pend <= 1'b0;
			pend_wr <= 1'b0;
			pend_idx <= IDX_NONE;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
		else if (!pend && HSEL && HTRANS[1] && HREADY)
		begin
			pend <= 1'b1;
			pend_wr <= HWRITE;
			pend_idx <= (HADDR[31:10] == 22'h0) ? HADDR[9:2] : IDX_NONE;
			HREADYOUT <= 1'b0;
		end
		else if (pend)
		begin
			pend <= 1'b0;
			HREADYOUT <= 1'b1;
		end

	always_ff @(posedge SYS_CLK or negedge RST_N)
		if (!RST_N)
			HRDATA <= 32'h00000000;
		else if (pend && !pend_wr)
			HRDATA <= {24'h000000, rd_reg(pend_idx)};

	assign wr = pend && pend_wr;

	// ----------------------------------------------------------------
	// Direct registers
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N)
		if (!RST_N)
		begin
			ctl <= CTL_RST;
			cfg <= CFG_RST;
			ia <= 8'h00;
			red_lv <= LVL_RST;
			grn_lv <= LVL_RST;
			blu_lv <= LVL_RST;
			tsc <= TSC_RST;
		end
		else if (wr)
			case (pend_idx)
				IDX_CTL: ctl <= HWDATA[7:0];
				IDX_CFG: cfg <= HWDATA[7:0];
				IDX_IA: ia <= HWDATA[7:0];
				IDX_RED: red_lv <= HWDATA[7:0];
				IDX_GRN: grn_lv <= HWDATA[7:0];
				IDX_BLU: blu_lv <= HWDATA[7:0];
				IDX_TSC: tsc <= HWDATA[7:0];
				default: ;
			endcase

	always_ff @(posedge SYS_CLK or negedge RST_N)
		if (!RST_N)
		begin
			for (int i = 0; i < IND_DEPTH; i++)
				ind_mem[i] <= ind_default(i);
		end
		else if (wr && pend_idx == IDX_ID && ia < 8'(IND_DEPTH))
			ind_mem[ia[4:0]] <= HWDATA[7:0];

	// ----------------------------------------------------------------
	// Mode decode and pixel tick source
	// ----------------------------------------------------------------
	assign tmode = cfg[CFG_MODE_LSB +: 2];
	assign ext_mode = (tmode == TM_EXT) || (tmode == 2'h3);
	assign auto = cfg[CFG_SCROLL];
	assign tick = (tmode == TM_INT) ? osc_tick : PIX_VALID;
	assign hact = dim(ind_mem[IND_HACT], ind_mem[IND_HACT + 5'h01]);
	assign htot = dim(ind_mem[IND_HTOT], ind_mem[IND_HTOT + 5'h01]);
	assign vact = dim(ind_mem[IND_VACT], ind_mem[IND_VACT + 5'h01]);
	assign vtot = dim(ind_mem[IND_VTOT], ind_mem[IND_VTOT + 5'h01]);
	assign hsize = ext_mode ? h_meas : hact;
	assign vsize = ext_mode ? v_meas : vact;

	always_ff @(posedge SYS_CLK or negedge RST_N)
		if (!RST_N)
		begin
			osc_cnt <= 8'h00;
			osc_tick <= 1'b0;
		end
		else if (osc_cnt == 8'h00)
		begin
			osc_cnt <= ind_mem[IND_OSC];
			osc_tick <= 1'b1;
		end
		else
		begin
			osc_cnt <= osc_cnt - 8'h01;
			osc_tick <= 1'b0;
		end

	// ----------------------------------------------------------------
	// Internal timing generator
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N)
		if (!RST_N)
		begin
			hcnt <= 12'h000;
			vcnt <= 12'h000;
		end
		else if (ext_mode)
		begin
			hcnt <= 12'h000;
			vcnt <= 12'h000;
		end
		else if (tick)
		begin
			hcnt <= (hcnt >= htot - 12'h001) ? 12'h000 : hcnt + 12'h001;
			if (hcnt >= htot - 12'h001)
				vcnt <= (vcnt >= vtot - 12'h001) ? 12'h000 : vcnt + 12'h001;
		end

	always_comb
	begin
		if (ext_mode)
		begin
			src_de = DE_IN;
			src_hs = HS_IN;
			src_vs = VS_IN;
		end
		else
		begin
			src_de = (hcnt < hact) && (vcnt < vact);
			src_hs = (hcnt >= hact) && (hcnt < hact + {4'h0, ind_mem[IND_HSW]});
			src_vs = (vcnt >= vact) && (vcnt < vact + {4'h0, ind_mem[IND_VSW]});
		end
		if (!tick)
			frame_end = 1'b0;
		else if (ext_mode)
			frame_end = (src_vs && !d1_vs) || (!src_de && h_meas != 12'h000
				&& y != 12'h000 && blank_cnt == {h_meas, 1'b0});
		else
			frame_end = (hcnt >= htot - 12'h001) && (vcnt >= vtot - 12'h001);
	end

	// ----------------------------------------------------------------
	// Position counters and frame measurement
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N)
		if (!RST_N)
		begin
			d1_de <= 1'b0;
			d1_hs <= 1'b0;
			d1_vs <= 1'b0;
			x <= 12'h000;
			y <= 12'h000;
			h_meas <= 12'h000;
			v_meas <= 12'h000;
			blank_cnt <= 13'h0000;
		end
		else if (tick)
		begin
			d1_de <= src_de;
			d1_hs <= src_hs;
			d1_vs <= src_vs;
			if (src_de)
				x <= d1_de ? x + 12'h001 : 12'h000;
			if (d1_de && !src_de)
				h_meas <= x + 12'h001;
			if (frame_end)
			begin
				y <= 12'h000;
				v_meas <= y;
			end
			else if (d1_de && !src_de)
				y <= y + 12'h001;
			if (src_de)
				blank_cnt <= 13'h0000;
			else if (blank_cnt != 13'h1FFF)
				blank_cnt <= blank_cnt + 13'h0001;
		end

	// ----------------------------------------------------------------
	// Auto-scroll sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N)
		if (!RST_N)
		begin
			slot <= 4'h0;
			frame_cnt <= 4'h0;
		end
		else if (!auto)
		begin
			slot <= 4'h0;
			frame_cnt <= 4'h0;
		end
		else if (frame_end)
		begin
			if (frame_cnt == tsc[TSC_HOLD_LSB +: 4])
			begin
				frame_cnt <= 4'h0;
				slot <= (slot == tsc[TSC_LAST_LSB +: 4]) ? 4'h0 : slot + 4'h1;
			end
			else
				frame_cnt <= frame_cnt + 4'h1;
		end

	assign cur_pat = auto ? slot_pat(slot) : ctl[CTL_SEL_W-1:0];

	// ----------------------------------------------------------------
	// Pattern colour
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [7:0] h, v;
		logic [1:0] s;
		h = scale(x, hsize);
		v = scale(y, vsize);
		s = h[7:6] ^ {2{ctl[CTL_VCOM_REV]}};
		case (cur_pat)
			PAT_WHITE: pix = 24'hFFFFFF;
			PAT_BLACK: pix = 24'h000000;
			PAT_RED: pix = 24'hFF0000;
			PAT_GREEN: pix = 24'h00FF00;
			PAT_BLUE: pix = 24'h0000FF;
			PAT_HGRAY: pix = {h, h, h};
			PAT_HGRAY + 5'h01: pix = {h, 16'h0000};
			PAT_HGRAY + 5'h02: pix = {8'h00, h, 8'h00};
			PAT_HGRAY + 5'h03: pix = {16'h0000, h};
			PAT_VGRAY: pix = {v, v, v};
			PAT_VGRAY + 5'h01: pix = {v, 16'h0000};
			PAT_VGRAY + 5'h02: pix = {8'h00, v, 8'h00};
			PAT_VGRAY + 5'h03: pix = {16'h0000, v};
			PAT_CUSTOM: pix = {red_lv, grn_lv, blu_lv};
			PAT_CHECK:
				if (x[CHK_BIT] ^ y[CHK_BIT])
					pix = ctl[CTL_CHK_CUST] ? {red_lv, grn_lv, blu_lv} : 24'hFFFFFF;
				else
					pix = 24'h000000;
			PAT_VCOM:
				case (s)
					2'h0: pix = 24'hFFFF00;
					2'h1: pix = 24'h00FFFF;
					2'h2: pix = 24'h0000FF;
					default: pix = 24'hFF0000;
				endcase
			PAT_BARS:
				case (h[7:5])
					3'h0: pix = 24'hFFFFFF;
					3'h1: pix = 24'hFFFF00;
					3'h2: pix = 24'h00FFFF;
					3'h3: pix = 24'h00FF00;
					3'h4: pix = 24'hFF00FF;
					3'h5: pix = 24'hFF0000;
					3'h6: pix = 24'h0000FF;
					default: pix = 24'h000000;
				endcase
			default: pix = 24'h000000;
		endcase
		if (cfg[CFG_INV])
			pix = ~pix;
		if (cfg[CFG_18B])
			pix = pix & {3{LSB_MASK}};
	end

	// ----------------------------------------------------------------
	// Output stage, two pixel ticks behind the source
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N)
		if (!RST_N)
		begin
			DE_OUT <= 1'b0;
			HS_OUT <= 1'b0;
			VS_OUT <= 1'b0;
			RED_OUT <= 8'h00;
			GREEN_OUT <= 8'h00;
			BLUE_OUT <= 8'h00;
		end
		else if (tick)
		begin
			DE_OUT <= d1_de;
			HS_OUT <= d1_hs;
			VS_OUT <= d1_vs;
			{RED_OUT, GREEN_OUT, BLUE_OUT} <= d1_de ? pix : 24'h000000;
		end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence two_ticks_ext;
		tick && ext_mode ##1 !tick && ext_mode ##1 tick && ext_mode;
	endsequence

	a_ext_delay: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		two_ticks_ext |=> DE_OUT == $past(DE_IN, 3) && HS_OUT == $past(HS_IN, 3)
		&& VS_OUT == $past(VS_IN, 3))
		else $error("sync not delayed by two pixel clocks");

	a_white_plain: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		tick && d1_de && cur_pat == PAT_WHITE && cfg == CFG_RST |=> RED_OUT == 8'hFF
		&& BLUE_OUT == 8'hFF)
		else $error("white pattern not full scale");

	a_invert_out: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		tick && d1_de && cur_pat == PAT_RED && cfg[CFG_INV] && !cfg[CFG_18B]
		|=> RED_OUT == 8'h00 && GREEN_OUT == 8'hFF && BLUE_OUT == 8'hFF)
		else $error("inverted red is not cyan");

	a_low_bits: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		tick && cfg[CFG_18B] |=> RED_OUT[1:0] == 2'h0 && GREEN_OUT[1:0] == 2'h0
		&& BLUE_OUT[1:0] == 2'h0)
		else $error("18-bit mode left low bits set");

	a_custom_color: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		tick && d1_de && cur_pat == PAT_CUSTOM && cfg[1:0] == 2'h0
		|=> {RED_OUT, GREEN_OUT, BLUE_OUT} == $past({red_lv, grn_lv, blu_lv}))
		else $error("custom colour not taken from level registers");

	a_no_bars: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		auto |-> cur_pat != PAT_BARS && cur_pat != 5'h00)
		else $error("scroll sequence produced colour bars");

	a_vblank_detect: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		tick && ext_mode && !src_de && h_meas != 12'h000 && y != 12'h000
		&& blank_cnt == {h_meas, 1'b0} |=> y == 12'h000 && v_meas == $past(y))
		else $error("long blank did not end the frame");

	a_scroll_step: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		frame_end && auto && $stable(auto) && frame_cnt == tsc[3:0]
		&& slot != tsc[7:4] |=> slot == $past(slot) + 4'h1 && frame_cnt == 4'h0)
		else $error("scroll slot did not advance");

	a_ind_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		wr && pend_idx == IDX_ID && ia < 8'h10 |=> ind_mem[$past(ia[4:0])] == $past(HWDATA[7:0]))
		else $error("indirect write lost");
endmodule

// ==== vtpg_src.sv ====
// Video source model that feeds timing into the generator
`timescale 1ns/1ps
module vtpg_src (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic no_vs,
	output logic pix,
	output logic de,
	output logic hs,
	output logic vs
);
	logic [3:0] x;
	logic [2:0] y;
	// --------------------------------------------------------------
	// Frame of 12 x 6 pixels, 8 x 4 active, one pixel every 2 clocks
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pix <= 1'b0;
			de <= 1'b0;
			hs <= 1'b0;
			vs <= 1'b0;
			x <= 4'h0;
			y <= 3'h0;
		end
		else if (en && !pix)
		begin
			pix <= 1'b1;
			de <= (x < 4'h8) && (y < 3'h4);
			hs <= (x == 4'h9) || (x == 4'hA);
			vs <= !no_vs && (y == 3'h4);
			x <= (x == 4'hB) ? 4'h0 : x + 4'h1;
			if (x == 4'hB)
				y <= (y == 3'h5) ? 3'h0 : y + 3'h1;
		end
		else
			pix <= 1'b0;
	end
endmodule

// ==== video_test_pattern_generator_test.sv ====
// Self-checking testbench for the video test pattern generator
`timescale 1ns/1ps
module video_test_pattern_generator_test;
	import vtpg_pkg::*;
	logic SYS_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [2:0] HSIZE = 3'h2;
	logic [31:0] HWDATA = 32'h0;
	logic [31:0] HRDATA;
	logic HREADYOUT;
	logic HRESP;
	logic pv, de_i, hs_i, vs_i, DE_OUT, HS_OUT, VS_OUT;
	logic [7:0] RED_OUT, GREEN_OUT, BLUE_OUT;
	logic src_en = 1'b0;
	logic no_vs = 1'b0;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	bit vid_on = 0;
	bit col_on = 0;
	bit inv = 0;
	bit b18 = 0;
	logic [4:0] pat = 5'h1;
	logic [7:0] cr, cg, cb;
	logic [2:0] prv = 3'h0;
	logic [2:0] cur = 3'h0;
	logic [31:0] rd;
	logic [15:0] tim [11] = '{16'h0004, 16'h0100, 16'h0208, 16'h0300, 16'h0401,
		16'h0502, 16'h0600, 16'h0704, 16'h0800, 16'h0901, 16'h0A01};
	logic [4:0] pats [7] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0E, 5'h06};
	logic [4:0] sq [4] = '{5'h03, 5'h01, 5'h0E, 5'h03};
	int px = -1;

	always #50 SYS_CLK = ~SYS_CLK;

	vtpg_src src (.clk(SYS_CLK), .rst_n(RST_N), .en(src_en), .no_vs(no_vs),
		.pix(pv), .de(de_i), .hs(hs_i), .vs(vs_i));

	vtpg_top dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.PIX_VALID(pv), .DE_IN(de_i), .HS_IN(hs_i), .VS_IN(vs_i), .DE_OUT(DE_OUT),
		.HS_OUT(HS_OUT), .VS_OUT(VS_OUT), .RED_OUT(RED_OUT), .GREEN_OUT(GREEN_OUT),
		.BLUE_OUT(BLUE_OUT));

	// --------------------------------------------------------------
	// Reporting
	// --------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	task automatic summarize;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge SYS_CLK)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_errors++;
			summarize;
		end
	end

	// --------------------------------------------------------------
	// AHB-Lite master, one word transfer
	// --------------------------------------------------------------
	task automatic bus(input bit wr, input logic [7:0] idx, input logic [7:0] wd);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {22'h0, idx, 2'h0};
		HWRITE <= wr;
		@(posedge SYS_CLK);
		while (HREADYOUT !== 1'b1)
			@(posedge SYS_CLK);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= {24'h0, wd};
		@(posedge SYS_CLK);
		while (HREADYOUT !== 1'b1)
			@(posedge SYS_CLK);
		rd = HRDATA;
		chk("hresp", 32'h0, {31'h0, HRESP});
	endtask

	task automatic ind_wr(input logic [7:0] i, input logic [7:0] v);
		bus(1, IDX_IA, i);
		bus(1, IDX_ID, v);
	endtask

	task automatic ind_rd(input logic [7:0] i, input logic [7:0] e, input string nm);
		bus(1, IDX_IA, i);
		bus(0, IDX_ID, 8'h0);
		chk(nm, {24'h0, e}, rd);
	endtask

	// Waits for a fresh active run, checks its colour and counts its cycles
	task automatic de_run(input logic [23:0] e, output int len);
		int w;
		w = 0;
		len = 0;
		while (DE_OUT !== 1'b0 && w < 2000)
		begin
			@(posedge SYS_CLK);
			#1;
			w++;
		end
		while (DE_OUT !== 1'b1 && w < 2000)
		begin
			@(posedge SYS_CLK);
			#1;
			w++;
		end
		chk("run rgb", {8'h0, e}, {8'h0, RED_OUT, GREEN_OUT, BLUE_OUT});
		while (DE_OUT === 1'b1 && len < 50)
		begin
			@(posedge SYS_CLK);
			#1;
			len++;
		end
	endtask

	// --------------------------------------------------------------
	// Colour and timing model
	// --------------------------------------------------------------
	function automatic logic [23:0] ecol(input logic [4:0] p);
		logic [23:0] c;
		case (p)
			5'h01: c = 24'hFFFFFF;
			5'h02: c = 24'h000000;
			5'h03: c = 24'hFF0000;
			5'h04: c = 24'h00FF00;
			5'h05: c = 24'h0000FF;
			5'h06: c = {3{8'((px * 256) / 8)}};
			default: c = {cr, cg, cb};
		endcase
		if (inv)
			c = ~c;
		if (b18)
			c = c & {3{LSB_MASK}};
		return c;
	endfunction

	always @(posedge SYS_CLK)
	begin
		if (RST_N && pv && vid_on)
		begin
			prv = cur;
			cur = {de_i, hs_i, vs_i};
			#1;
			px = DE_OUT ? px + 1 : -1;
			chk("sync", {29'h0, prv}, {29'h0, DE_OUT, HS_OUT, VS_OUT});
			if (col_on)
				chk("rgb", {8'h0, DE_OUT ? ecol(pat) : 24'h0}, {8'h0, RED_OUT, GREEN_OUT, BLUE_OUT});
		end
	end

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	logic [7:0] ri [7] = '{IDX_CTL, IDX_CFG, IDX_TSC, IDX_RED, IDX_GRN, IDX_BLU, 8'h70};
	logic [7:0] rv [7] = '{CTL_RST, CFG_RST, TSC_RST, LVL_RST, LVL_RST, LVL_RST, 8'h00};
	int n;
	initial
	begin
		void'($urandom(38));
		repeat (2) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		for (int i = 0; i < 7; i++)
		begin
			bus(0, ri[i], 8'h0);
			chk("reset value", {24'h0, rv[i]}, rd);
		end
		ind_rd({3'h0, IND_HACT}, HACT_RST[7:0], "hact lo");
		ind_rd({3'h0, IND_OSC}, OSC_RST, "osc");
		bus(0, IDX_IA, 8'h0);
		chk("index", {27'h0, IND_OSC}, rd);
		src_en <= 1'b1;
		vid_on = 1;
		for (int p = 0; p < 7; p++)
			for (int c = 0; c < 4; c++)
			begin
				col_on = 0;
				cr = 8'($urandom);
				cg = 8'($urandom);
				cb = 8'($urandom);
				bus(1, IDX_RED, cr);
				bus(1, IDX_GRN, cg);
				bus(1, IDX_BLU, cb);
				bus(1, IDX_CTL, {3'h0, pats[p]});
				bus(1, IDX_CFG, 8'(c));
				bus(0, IDX_BLU, 8'h0);
				chk("blue level", {24'h0, cb}, rd);
				pat = pats[p];
				inv = c[0];
				b18 = c[1];
				repeat (20) @(posedge SYS_CLK);
				col_on = 1;
				repeat (300) @(posedge SYS_CLK);
			end
		ind_wr({3'h0, IND_SLOT}, 8'h02);
		ind_wr({3'h0, IND_SLOT} + 8'h01, 8'h2D);
		bus(1, IDX_TSC, 8'h31);
		@(posedge vs_i);
		bus(1, IDX_CFG, 8'h13);
		for (int f = 0; f < 10; f++)
		begin
			pat = sq[(f / 2) % 4];
			@(posedge vs_i);
		end
		col_on = 0;
		ind_rd(IND_HMEAS, 8'h08, "width");
		ind_rd(IND_VMEAS, 8'h04, "height");
		vid_on = 0;
		@(posedge SYS_CLK);
		RST_N <= 1'b0;
		no_vs <= 1'b1;
		@(posedge SYS_CLK);
		RST_N <= 1'b1;
		cur = 3'h0;
		vid_on = 1;
		@(posedge SYS_CLK);
		bus(0, IDX_CFG, 8'h0);
		chk("reset value", {24'h0, CFG_RST}, rd);
		repeat (400) @(posedge SYS_CLK);
		ind_rd(IND_VMEAS, 8'h04, "height no vs");
		vid_on = 0;
		src_en <= 1'b0;
		for (int i = 0; i < 11; i++)
			ind_wr(tim[i][15:8], tim[i][7:0]);
		bus(1, IDX_CTL, {3'h0, PAT_RED});
		bus(1, IDX_CFG, {4'h0, TM_INT, 2'h0});
		de_run(24'hFF0000, n);
		chk("int line", 32'h00000008, 32'(n));
		src_en <= 1'b1;
		@(posedge SYS_CLK);
		bus(1, IDX_CFG, {4'h0, TM_INT_XCLK, 2'h0});
		de_run(24'hFF0000, n);
		chk("xclk line", 32'h00000008, 32'(n));
		summarize;
	end
endmodule
